// ### logic/addr_former.sv
`timescale 1ns/100ps
module addr_former (
  input wire logic [31:0] ptr_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] size_i,
  input wire logic short_i,
  output logic [31:0] eff_o,
  output logic [31:0] next_o,
  output logic wb_o
);
  logic [31:0] step;

  // step equals the access size
  always_comb begin
    case (size_i)
      xfer_pkg::SIZE_WORD: step = 32'h2;
      xfer_pkg::SIZE_LONG: step = 32'h4;
      default: step = 32'h1;
    endcase
  end

  // full mode uses all bits, short mode sign-extends bit 23
  assign eff_o = short_i ?
    {{8{ptr_i[xfer_pkg::SHORT_ADDR_BITS-1]}}, ptr_i[xfer_pkg::SHORT_ADDR_BITS-1:0]} :
    ptr_i;

  // 0x fixed without write-back, 10 increment, 11 decrement
  always_comb begin
    case (mode_i)
      2'h2: next_o = ptr_i + step;
      2'h3: next_o = ptr_i - step;
      default: next_o = ptr_i;
    endcase
  end
  assign wb_o = mode_i[1];
endmodule : addr_former

// ### logic/split_planner.sv
`timescale 1ns/100ps
module split_planner (
  input wire logic [1:0] addr_lo_i,
  input wire logic [2:0] remain_i,
  output logic [1:0] piece_size_o,
  output logic [2:0] piece_bytes_o
);
  // largest aligned piece that still fits the remaining bytes
  always_comb begin
    if (remain_i >= 3'h4 && addr_lo_i == 2'h0) begin
      piece_size_o = xfer_pkg::SIZE_LONG;
      piece_bytes_o = 3'h4;
    end else if (remain_i >= 3'h2 && !addr_lo_i[0]) begin
      piece_size_o = xfer_pkg::SIZE_WORD;
      piece_bytes_o = 3'h2;
    end else begin
      piece_size_o = xfer_pkg::SIZE_BYTE;
      piece_bytes_o = 3'h1;
    end
  end
endmodule : split_planner

// ### logic/xfer_engine.sv
`timescale 1ns/100ps
// Summary of operation
// - chain enable 0 stops chaining; 1 processes a further information set.
// - chain condition 0 chains always; 1 chains only at counter zero.
// - a chained transfer skips count check and leaves flag and enable set.
// - irq select 1 requests CPU interrupt per transfer; 0 only at count end. Here a chained transfer requests none.
// - area side 0 makes destination the repeat area; 1 makes source it.
// - destination mode 0x holds pointer without write-back; 10 increments.
// - source pointer is 32 bits, all used in full address mode.
// - short mode uses low 24 bits, upper bits copy bit 23.
// - misaligned word or longword source accesses split into smaller cycles.
// - mode word and source pointer are not CPU accessible.
// - source mode 0x fixed, 10 increments, 11 decrements by the step.
module xfer_engine (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [4:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic ACT_I,
  input wire xfer_pkg::xfer_info_s INFO_I,
  output logic ACT_READY_O,
  input wire logic CNT_ZERO_I,
  input wire logic REPEAT_MODE_I,
  output xfer_pkg::mem_req_s MEM_REQ_O,
  input wire logic MEM_ACK_I,
  input wire logic [31:0] MEM_RDATA_I,
  output xfer_pkg::ptr_wb_s SRC_WB_O,
  output xfer_pkg::ptr_wb_s DST_WB_O,
  output logic CHAIN_NEXT_O,
  output logic CLEAR_SRC_O,
  output logic CPU_IRQ_REQ_O,
  output logic IRQ_O
);
  xfer_pkg::state_e state_q;
  logic [7:0] mode_q;
  logic [1:0] size_q;
  logic [1:0] src_mode_q;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  logic [31:0] src_start_q;
  logic [31:0] dst_start_q;
  logic [31:0] data_q;
  logic [2:0] remain_q;
  logic [1:0] offs_q;
  logic [1:0] ctrl_q;
  logic [xfer_pkg::EV_BITS-1:0] ev_stat_q;
  logic [xfer_pkg::EV_BITS-1:0] ev_mask_q;
  logic [15:0] done_cnt_q;
  logic [31:0] src_eff, src_next, dst_eff, dst_next, rd_addr;
  logic src_wb, dst_wb;
  logic [1:0] piece_size;
  logic [2:0] piece_bytes;
  logic chain, end_of_count, finish, split_ev;
  logic [xfer_pkg::EV_BITS-1:0] ev_set;
  logic bus_hit, bus_wr;

  // byte count of an access size
  function automatic logic [2:0] size_bytes(input logic [1:0] sz);
    case (sz)
      xfer_pkg::SIZE_WORD: size_bytes = 3'h2;
      xfer_pkg::SIZE_LONG: size_bytes = 3'h4;
      default: size_bytes = 3'h1;
    endcase
  endfunction : size_bytes

  // source and destination address forming
  addr_former u_src_former (
    .ptr_i(src_q),
    .mode_i(src_mode_q),
    .size_i(size_q),
    .short_i(ctrl_q[xfer_pkg::CTRL_SHORT_MODE]),
    .eff_o(src_eff),
    .next_o(src_next),
    .wb_o(src_wb)
  );
  addr_former u_dst_former (
    .ptr_i(dst_q),
    .mode_i({mode_q[xfer_pkg::MODE_DEST_HI], mode_q[xfer_pkg::MODE_DEST_LO]}),
    .size_i(size_q),
    .short_i(ctrl_q[xfer_pkg::CTRL_SHORT_MODE]),
    .eff_o(dst_eff),
    .next_o(dst_next),
    .wb_o(dst_wb)
  );

  // piece planning for the source read
  assign rd_addr = src_eff + {30'h0, offs_q};
  split_planner u_split (
    .addr_lo_i(rd_addr[1:0]),
    .remain_i(remain_q),
    .piece_size_o(piece_size),
    .piece_bytes_o(piece_bytes)
  );

  // decisions taken at the end of one data transfer
  assign finish = (state_q == xfer_pkg::ST_FINISH);
  assign chain = mode_q[xfer_pkg::MODE_CHAIN_EN] &
    (!mode_q[xfer_pkg::MODE_CHAIN_COND] | CNT_ZERO_I);
  assign end_of_count = !chain & CNT_ZERO_I;
  assign split_ev = (state_q == xfer_pkg::ST_READ) & MEM_ACK_I &
    (piece_bytes != remain_q);
  assign ACT_READY_O = (state_q == xfer_pkg::ST_IDLE) & ctrl_q[xfer_pkg::CTRL_ENABLE];

  // transfer sequencer
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q <= xfer_pkg::ST_IDLE;
    end else begin
      case (state_q)
        xfer_pkg::ST_IDLE: begin
          if (ACT_I && ACT_READY_O) begin
            state_q <= xfer_pkg::ST_READ;
          end
        end
        xfer_pkg::ST_READ: begin
          if (MEM_ACK_I && piece_bytes == remain_q) begin
            state_q <= xfer_pkg::ST_WRITE;
          end
        end
        xfer_pkg::ST_WRITE: begin
          if (MEM_ACK_I) begin
            state_q <= xfer_pkg::ST_FINISH;
          end
        end
        xfer_pkg::ST_FINISH: begin
          state_q <= xfer_pkg::ST_IDLE;
        end
        default: begin
          state_q <= xfer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // transfer information, held only internally
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      mode_q <= 8'h00;
      size_q <= xfer_pkg::SIZE_BYTE;
      src_mode_q <= 2'h0;
      src_q <= 32'h0;
      dst_q <= 32'h0;
      src_start_q <= 32'h0;
      dst_start_q <= 32'h0;
    end else if (ACT_I && ACT_READY_O) begin
      mode_q <= INFO_I.mode & ~xfer_pkg::MODE_RESERVED_MASK;
      size_q <= INFO_I.size;
      src_mode_q <= INFO_I.src_mode;
      src_q <= INFO_I.src;
      dst_q <= INFO_I.dst;
      src_start_q <= INFO_I.src;
      dst_start_q <= INFO_I.dst;
    end else if (finish) begin
      // repeat area goes back to its start at counter zero
      if (REPEAT_MODE_I && CNT_ZERO_I && !mode_q[xfer_pkg::MODE_AREA_SIDE]) begin
        dst_q <= dst_start_q;
      end else begin
        dst_q <= dst_next;
      end
      if (REPEAT_MODE_I && CNT_ZERO_I && mode_q[xfer_pkg::MODE_AREA_SIDE]) begin
        src_q <= src_start_q;
      end else begin
        src_q <= src_next;
      end
    end
  end

  // source read split into pieces and assembled high byte first
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      data_q <= 32'h0;
      remain_q <= 3'h0;
      offs_q <= 2'h0;
    end else if (ACT_I && ACT_READY_O) begin
      data_q <= 32'h0;
      remain_q <= size_bytes(INFO_I.size);
      offs_q <= 2'h0;
    end else if (state_q == xfer_pkg::ST_READ && MEM_ACK_I) begin
      case (piece_size)
        xfer_pkg::SIZE_WORD: data_q <= {data_q[15:0], MEM_RDATA_I[15:0]};
        xfer_pkg::SIZE_LONG: data_q <= MEM_RDATA_I;
        default: data_q <= {data_q[23:0], MEM_RDATA_I[7:0]};
      endcase
      remain_q <= remain_q - piece_bytes;
      offs_q <= offs_q + piece_bytes[1:0];
    end
  end

  // memory request, combinational handshake from registered state
  always_comb begin
    MEM_REQ_O = '0;
    if (state_q == xfer_pkg::ST_READ) begin
      MEM_REQ_O.valid = 1'b1;
      MEM_REQ_O.size = piece_size;
      MEM_REQ_O.addr = rd_addr;
    end else if (state_q == xfer_pkg::ST_WRITE) begin
      MEM_REQ_O.valid = 1'b1;
      MEM_REQ_O.we = 1'b1;
      MEM_REQ_O.size = size_q;
      MEM_REQ_O.addr = dst_eff;
      MEM_REQ_O.wdata = data_q;
    end
  end

  // end-of-transfer pulses and pointer write-back
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      CHAIN_NEXT_O <= 1'b0;
      CLEAR_SRC_O <= 1'b0;
      CPU_IRQ_REQ_O <= 1'b0;
      SRC_WB_O <= '0;
      DST_WB_O <= '0;
    end else begin
      CHAIN_NEXT_O <= finish & chain;
      CLEAR_SRC_O <= finish & !chain &
        (end_of_count | mode_q[xfer_pkg::MODE_IRQ_EVERY]);
      CPU_IRQ_REQ_O <= finish & !chain &
        (end_of_count | mode_q[xfer_pkg::MODE_IRQ_EVERY]);
      SRC_WB_O.valid <= finish & src_wb;
      SRC_WB_O.addr <= src_next;
      DST_WB_O.valid <= finish & dst_wb;
      DST_WB_O.addr <= dst_next;
    end
  end

  // wishbone slave decode, one registered answer per strobe, one cycle later
  assign bus_hit = CYC_I & STB_I & !ACK_O;
  assign bus_wr = bus_hit & WE_I & SEL_I[0];

  // bus acknowledge and read data
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
    end else begin
      ACK_O <= bus_hit;
      if (bus_hit && !WE_I) begin
        case (ADR_I)
          xfer_pkg::OFF_CTRL: DAT_O <= {30'h0, ctrl_q};
          xfer_pkg::OFF_STATUS: DAT_O <= {13'h0, state_q, done_cnt_q};
          xfer_pkg::OFF_IRQ_STAT: DAT_O <= {28'h0, ev_stat_q};
          xfer_pkg::OFF_IRQ_MASK: DAT_O <= {28'h0, ev_mask_q};
          default: DAT_O <= 32'h0;
        endcase
      end
    end
  end

  // control and mask registers
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ctrl_q <= xfer_pkg::CTRL_RESET;
      ev_mask_q <= xfer_pkg::IRQ_MASK_RESET;
    end else if (bus_wr) begin
      if (ADR_I == xfer_pkg::OFF_CTRL) begin
        ctrl_q <= DAT_I[1:0];
      end
      if (ADR_I == xfer_pkg::OFF_IRQ_MASK) begin
        ev_mask_q <= DAT_I[xfer_pkg::EV_BITS-1:0];
      end
    end
  end

  // completed transfer counter
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      done_cnt_q <= 16'h0;
    end else if (finish) begin
      done_cnt_q <= done_cnt_q + 16'h1;
    end
  end

  // sticky events, set wins over write-one clear
  always_comb begin
    ev_set = '0;
    ev_set[xfer_pkg::EV_DONE] = finish & end_of_count;
    ev_set[xfer_pkg::EV_CPU_REQ] = finish & !chain &
      (end_of_count | mode_q[xfer_pkg::MODE_IRQ_EVERY]);
    ev_set[xfer_pkg::EV_CHAIN] = finish & chain;
    ev_set[xfer_pkg::EV_SPLIT] = split_ev;
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ev_stat_q <= '0;
    end else if (bus_wr && ADR_I == xfer_pkg::OFF_IRQ_STAT) begin
      ev_stat_q <= (ev_stat_q & ~DAT_I[xfer_pkg::EV_BITS-1:0]) | ev_set;
    end else begin
      ev_stat_q <= ev_stat_q | ev_set;
    end
  end
  assign IRQ_O = |(ev_stat_q & ev_mask_q);

  // checks
  property p_chain_off;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (finish && !mode_q[xfer_pkg::MODE_CHAIN_EN]) |=> !CHAIN_NEXT_O;
  endproperty
  a_chain_off: assert property (p_chain_off) else $error("chain with enable off");

  property p_chain_always;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (finish && mode_q[xfer_pkg::MODE_CHAIN_EN] && !mode_q[xfer_pkg::MODE_CHAIN_COND])
      |=> CHAIN_NEXT_O;
  endproperty
  a_chain_always: assert property (p_chain_always) else $error("missed chain");

  property p_chain_no_clear;
    @(posedge CLK_I) disable iff (!RST_B_I)
      CHAIN_NEXT_O |-> !CLEAR_SRC_O && !CPU_IRQ_REQ_O;
  endproperty
  a_chain_no_clear: assert property (p_chain_no_clear) else $error("clear on chain");

  property p_irq_every;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (finish && !chain && mode_q[xfer_pkg::MODE_IRQ_EVERY]) |=> CPU_IRQ_REQ_O;
  endproperty
  a_irq_every: assert property (p_irq_every) else $error("missed cpu request");

  property p_irq_count;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (finish && !mode_q[xfer_pkg::MODE_IRQ_EVERY] && !CNT_ZERO_I) |=> !CPU_IRQ_REQ_O;
  endproperty
  a_irq_count: assert property (p_irq_count) else $error("early cpu request");

  property p_dest_fixed;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (finish && !mode_q[xfer_pkg::MODE_DEST_HI] && !REPEAT_MODE_I)
      |=> !DST_WB_O.valid && dst_q == $past(dst_q);
  endproperty
  a_dest_fixed: assert property (p_dest_fixed) else $error("fixed pointer moved");

  property p_dest_dec;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (finish && mode_q[xfer_pkg::MODE_DEST_HI] && mode_q[xfer_pkg::MODE_DEST_LO]
        && !REPEAT_MODE_I)
      |=> dst_q == $past(dst_q) - {29'h0, size_bytes(size_q)};
  endproperty
  a_dest_dec: assert property (p_dest_dec) else $error("bad decrement");

  property p_short_addr;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (MEM_REQ_O.valid && !MEM_REQ_O.we && ctrl_q[xfer_pkg::CTRL_SHORT_MODE])
      |-> MEM_REQ_O.addr[31:24] == {8{MEM_REQ_O.addr[23]}} || offs_q != 2'h0;
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("short address unextended");

  property p_split_align;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (MEM_REQ_O.valid && !MEM_REQ_O.we)
      |-> !(MEM_REQ_O.addr[0] && MEM_REQ_O.size != xfer_pkg::SIZE_BYTE)
        && !(MEM_REQ_O.addr[1] && MEM_REQ_O.size == xfer_pkg::SIZE_LONG);
  endproperty
  a_split_align: assert property (p_split_align) else $error("misaligned read piece");
endmodule : xfer_engine

// ### logic/xfer_pkg.sv
package xfer_pkg;
  // mode word field positions
  localparam int MODE_CHAIN_EN = 7;
  localparam int MODE_CHAIN_COND = 6;
  localparam int MODE_IRQ_EVERY = 5;
  localparam int MODE_AREA_SIDE = 4;
  localparam int MODE_DEST_HI = 3;
  localparam int MODE_DEST_LO = 2;
  localparam logic [7:0] MODE_RESERVED_MASK = 8'h03;
  // access size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  // short address mode keeps this many low bits
  localparam int SHORT_ADDR_BITS = 24;
  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;
  // control fields and reset values
  localparam int CTRL_SHORT_MODE = 0;
  localparam int CTRL_ENABLE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  // interrupt status bits
  localparam int EV_DONE = 0;
  localparam int EV_CPU_REQ = 1;
  localparam int EV_CHAIN = 2;
  localparam int EV_SPLIT = 3;
  localparam int EV_BITS = 4;
  // bus wait time between request and answer, one cycle
  localparam int ACK_LATENCY_CYCLES = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_WRITE = 3'h2,
    ST_FINISH = 3'h3
  } state_e;

  typedef struct packed {
    logic [7:0] mode;
    logic [1:0] size;
    logic [1:0] src_mode;
    logic [31:0] src;
    logic [31:0] dst;
  } xfer_info_s;

  typedef struct packed {
    logic valid;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } ptr_wb_s;
endpackage : xfer_pkg

// ### tb/mem_partner.sv
`timescale 1ns/100ps
module mem_partner (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire xfer_pkg::mem_req_s req_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [1:0] wait_q;
  logic [31:0] rd_q[$];
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  // big-endian piece: byte at address a holds a[7:0] + 8'h11
  function automatic logic [31:0] piece(input logic [31:0] a, input logic [1:0] sz);
    logic [31:0] v;
    v = 32'h0;
    for (int b = 0; b < (1 << sz); b++) v = {v[23:0], a[7:0] + b[7:0] + 8'h11};
    return v;
  endfunction : piece
  // answer a held request at once or after three waits; released data toggles
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      rdata_o <= 32'h0;
    end else if (req_i.valid && !ack_o && (!slow_i || wait_q == 2'h3)) begin
      ack_o <= 1'b1;
      wait_q <= 2'h0;
      if (req_i.we) begin
        wr_addr <= req_i.addr;
        wr_data <= req_i.wdata;
      end else begin
        rd_q.push_back(req_i.addr);
        rdata_o <= piece(req_i.addr, req_i.size);
      end
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i.valid && !ack_o) wait_q <= wait_q + 2'h1;
    end
  end
endmodule : mem_partner

// ### tb/tb_xfer_engine.sv
`timescale 1ns/100ps
module tb_xfer_engine;
  logic CLK_I = 0, RST_B_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0, ACT_I = 0;
  logic CNT_ZERO_I = 0, REPEAT_MODE_I = 0, slow = 0;
  logic [4:0] ADR_I = 5'h0;
  logic [3:0] SEL_I = 4'hf;
  logic [31:0] DAT_I = 32'h0, DAT_O, MEM_RDATA_I, rd;
  logic ACK_O, ACT_READY_O, MEM_ACK_I, CHAIN_NEXT_O, CLEAR_SRC_O, CPU_IRQ_REQ_O, IRQ_O;
  xfer_pkg::xfer_info_s INFO_I = '0;
  xfer_pkg::mem_req_s MEM_REQ_O;
  xfer_pkg::ptr_wb_s SRC_WB_O, DST_WB_O, swb, dwb;
  logic s_chain, s_clear, s_irq;
  int n_fail = 0, checked = 0;

  xfer_engine xfer_engine_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .ACT_I(ACT_I), .INFO_I(INFO_I), .ACT_READY_O(ACT_READY_O), .CNT_ZERO_I(CNT_ZERO_I),
    .REPEAT_MODE_I(REPEAT_MODE_I), .MEM_REQ_O(MEM_REQ_O), .MEM_ACK_I(MEM_ACK_I),
    .MEM_RDATA_I(MEM_RDATA_I), .SRC_WB_O(SRC_WB_O), .DST_WB_O(DST_WB_O),
    .CHAIN_NEXT_O(CHAIN_NEXT_O), .CLEAR_SRC_O(CLEAR_SRC_O), .CPU_IRQ_REQ_O(CPU_IRQ_REQ_O),
    .IRQ_O(IRQ_O));
  mem_partner mem_partner_i (.clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(MEM_REQ_O),
    .slow_i(slow), .ack_o(MEM_ACK_I), .rdata_o(MEM_RDATA_I));

  // clock and reset
  initial begin
    forever #5 CLK_I = ~CLK_I;
  end
  initial begin
    repeat (2) @(posedge CLK_I);
    RST_B_I <= 1'b1;
  end
  // catch the end-of-transfer pulses
  always @(posedge CLK_I) begin
    if (CHAIN_NEXT_O) s_chain <= 1'b1;
    if (CLEAR_SRC_O) s_clear <= 1'b1;
    if (CPU_IRQ_REQ_O) s_irq <= 1'b1;
    if (SRC_WB_O.valid) swb <= SRC_WB_O;
    if (DST_WB_O.valid) dwb <= DST_WB_O;
  end

  // 33 bits wide so that a write-back pulse is compared with its valid bit
  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // hold the request until ack is seen; a stuck slave is left to the watchdog
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wd);
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= adr;
    DAT_I <= wd;
    do begin
      @(posedge CLK_I);
    end while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask : wb

  task automatic xfer(input logic [7:0] mode, input logic [1:0] sz, input logic [1:0] sm,
                      input logic [31:0] src, input logic cz);
    int n;
    @(posedge CLK_I);
    ACT_I <= 1'b1;
    INFO_I <= {mode, sz, sm, src, 32'h9000_2000};
    CNT_ZERO_I <= cz;
    s_chain <= 1'b0;
    s_clear <= 1'b0;
    s_irq <= 1'b0;
    swb <= '0;
    dwb <= '0;
    mem_partner_i.rd_q.delete();
    @(posedge CLK_I);
    ACT_I <= 1'b0;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACT_READY_O !== 1'b1 && n < 200);
    @(posedge CLK_I);
    #1;
    chk("transfer end", 32'h1, {31'h0, n < 200});
  endtask : xfer

  function automatic logic [31:0] exp_data(input logic [31:0] a, input int nb);
    logic [31:0] v;
    v = 32'h0;
    for (int b = 0; b < nb; b++) v = {v[23:0], a[7:0] + b[7:0] + 8'h11};
    return v;
  endfunction : exp_data

  task automatic t_regs;
    wb(1'b0, xfer_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", {30'h0, xfer_pkg::CTRL_RESET}, rd);
    wb(1'b0, xfer_pkg::OFF_IRQ_MASK, 32'h0);
    chk("mask reset", {28'h0, xfer_pkg::IRQ_MASK_RESET}, rd);
    wb(1'b0, 5'h10, 32'h0);
    chk("unmapped read", 32'h0, rd);
    wb(1'b1, xfer_pkg::OFF_CTRL, 32'h2);
    chk("ready", 32'h1, {31'h0, ACT_READY_O});
    $display("test regs done");
  endtask : t_regs

  task automatic t_split;
    logic [1:0] szs[7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2};
    logic [1:0] sms[7] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [7:0] dms[7] = '{8'h08, 8'h0c, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h08};
    logic [3:0] los[7] = '{4'h3, 4'h1, 4'h2, 4'h1, 4'h4, 4'h2, 4'h3};
    int pcs[7] = '{1, 2, 2, 3, 1, 1, 3};
    logic [31:0] src, m, step;
    for (int i = 0; i < 7; i++) begin
      slow <= i[0];
      src = {28'h8000_100, los[i]};
      step = 32'h1 << szs[i];
      m = (szs[i] == 2'h2) ? 32'hffff_ffff : (32'h1 << (8 * step)) - 32'h1;
      xfer(dms[i], szs[i], sms[i], src, 1'b1);
      chk("pieces", pcs[i], mem_partner_i.rd_q.size());
      chk("first read addr", src, mem_partner_i.rd_q[0]);
      chk("write data", exp_data(src, step), mem_partner_i.wr_data & m);
      chk("write addr", 32'h9000_2000, mem_partner_i.wr_addr);
      chk("src wb", sms[i][1] ? {1'b1, sms[i][0] ? src - step : src + step} : 33'h0,
          swb);
      chk("dst wb", dms[i][3] ? {1'b1, dms[i][2] ? 32'h9000_2000 - step : 32'h9000_2000 + step}
          : 33'h0, dwb);
    end
    $display("test split done");
  endtask : t_split

  task automatic t_short;
    wb(1'b1, xfer_pkg::OFF_CTRL, 32'h3);
    xfer(8'h00, 2'h0, 2'h2, 32'hab80_0010, 1'b1);
    chk("short high", 32'hff80_0010, mem_partner_i.rd_q[0]);
    chk("short wb", {1'b1, 32'hab80_0011}, swb);
    xfer(8'h00, 2'h0, 2'h0, 32'h127f_0000, 1'b1);
    chk("short low", 32'h007f_0000, mem_partner_i.rd_q[0]);
    wb(1'b1, xfer_pkg::OFF_CTRL, 32'h2);
    $display("test short done");
  endtask : t_short

  // repeat mode: the area side reloads at counter zero, the other side steps
  task automatic t_repeat;
    @(posedge CLK_I);
    REPEAT_MODE_I <= 1'b1;
    xfer(8'h18, 2'h0, 2'h2, 32'h0000_0040, 1'b1);
    chk("src reload", 32'h0000_0040, xfer_engine_i.src_q);
    chk("dst stepped", 32'h9000_2001, xfer_engine_i.dst_q);
    xfer(8'h08, 2'h0, 2'h2, 32'h0000_0040, 1'b1);
    chk("src stepped", 32'h0000_0041, xfer_engine_i.src_q);
    chk("dst reload", 32'h9000_2000, xfer_engine_i.dst_q);
    xfer(8'h18, 2'h0, 2'h2, 32'h0000_0040, 1'b0);
    chk("src no reload", 32'h0000_0041, xfer_engine_i.src_q);
    @(posedge CLK_I);
    REPEAT_MODE_I <= 1'b0;
    $display("test repeat done");
  endtask : t_repeat

  task automatic t_end;
    logic ch, rq;
    logic [31:0] base;
    wb(1'b0, xfer_pkg::OFF_STATUS, 32'h0);
    base = rd;
    for (int k = 0; k < 16; k++) begin
      ch = k[3] & (!k[2] | k[0]);
      rq = !ch & (k[0] | k[1]);
      xfer({k[3], k[2], k[1], 5'h0}, 2'h0, 2'h0, 32'h0000_0040, k[0]);
      chk("chain", ch, s_chain);
      chk("clear", rq, s_clear);
      chk("cpu irq", rq, s_irq);
    end
    // idle state and sixteen more completed transfers
    wb(1'b0, xfer_pkg::OFF_STATUS, 32'h0);
    chk("transfer count", base + 32'h10, rd);
    $display("test end decisions done");
  endtask : t_end

  task automatic t_irq;
    wb(1'b1, xfer_pkg::OFF_IRQ_STAT, 32'hf);
    xfer(8'h00, 2'h1, 2'h0, 32'h0000_0041, 1'b1);
    wb(1'b0, xfer_pkg::OFF_IRQ_STAT, 32'h0);
    chk("split event", 32'h1, {31'h0, rd[xfer_pkg::EV_SPLIT]});
    chk("done event", 32'h1, {31'h0, rd[xfer_pkg::EV_DONE]});
    chk("irq masked", 32'h0, {31'h0, IRQ_O});
    wb(1'b1, xfer_pkg::OFF_IRQ_MASK, 32'h1 << xfer_pkg::EV_DONE);
    chk("irq on", 32'h1, {31'h0, IRQ_O});
    wb(1'b1, xfer_pkg::OFF_IRQ_STAT, 32'h1 << xfer_pkg::EV_DONE);
    @(posedge CLK_I);
    chk("irq cleared", 32'h0, {31'h0, IRQ_O});
    $display("test irq done");
  endtask : t_irq

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // watchdog
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    @(posedge RST_B_I);
    t_regs();
    t_split();
    t_short();
    t_repeat();
    t_end();
    t_irq();
    print_verdict();
  end
endmodule : tb_xfer_engine
